// ===== pkg/safe_state_pkg.sv
// Constants for the safe-state output and failure-sync block
package safe_state_pkg;
   localparam int CLK_MHZ = 40;
   localparam int SYNC_LEAD_US = 20;
   localparam int SYNC_DEBOUNCE_US = 20;
   localparam int SYNC_RELEASE_US = 30;
   localparam int SYNC_LEAD_CYC = SYNC_LEAD_US * CLK_MHZ;
   localparam int SYNC_DEBOUNCE_CYC = SYNC_DEBOUNCE_US * CLK_MHZ;
   localparam int SYNC_RELEASE_CYC = SYNC_RELEASE_US * CLK_MHZ;
   localparam int CNT_W = 11;
   // Register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_FLAGS = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   // Flag field positions in REG_FLAGS
   localparam int F_HOLD = 0;
   localparam int F_SOFT = 1;
   localparam int F_WDI = 2;
   localparam int F_CNT = 3;
   localparam int F_HARD = 4;
   localparam int NFLAG = 5;
   // Select field positions in REG_CTRL
   localparam int S_SOFT = 0;
   localparam int S_WDI = 1;
   localparam int S_CNT = 2;
   localparam int S_HARD = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [6:0] BASE_ADDR = 7'h08;
   localparam logic [6:0] TEST_ADDR = 7'h08;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [2:0] {ST_OFF, ST_WAIT_UP, ST_ON, ST_LEAD, ST_DOWN, ST_RELEASE} seq_t;
endpackage : safe_state_pkg

// ===== hdl/safe_state_cnt.sv
// Saturating cycle counter with terminal flag
`timescale 1ns/1ps
`default_nettype none
module safe_state_cnt #(
   parameter int LIMIT = 800
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic run,
   output logic done
);
   logic [safe_state_pkg::CNT_W-1:0] count;
   localparam logic [safe_state_pkg::CNT_W-1:0] LAST = safe_state_pkg::CNT_W'(LIMIT - 1);
   wire at_last = (count == LAST);
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         count <= '0;
      else if (!run)
         count <= '0;
      else if (!at_last)
         count <= count + 1'b1;
   end
   assign done = run && at_last;
endmodule : safe_state_cnt
`default_nettype wire

// ===== hdl/safe_state_top.sv
// Safe-state output and multi-chip failure-sync control
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module safe_state_top (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic fuse_loaded,
   input wire logic fuse_active_safe_mode,
   input wire logic fuse_sync_enable,
   input wire logic fuse_reset_kind,
   input wire logic [2:0] fuse_addr_sel,
   input wire logic config_test_pin,
   input wire logic host_reset_out,
   input wire logic analog_self_test,
   input wire logic regulator_fault,
   input wire logic current_limit_fault,
   input wire logic watchdog_input,
   input wire logic counter_wd_reset,
   input wire logic fault_timer_expired,
   input wire logic regulator_fault_limit,
   input wire logic watchdog_event_limit,
   input wire logic power_up_failure,
   input wire logic thermal_shutdown,
   input wire logic input_undervoltage_detect,
   input wire logic power_on_input,
   input wire logic outputs_off,
   input wire logic multi_chip_fail_sync_in,
   input wire logic bus_bit_strobe,
   input wire logic bus_word_end,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic safe_state_out_o,
   output logic safe_state_out_oe,
   output logic multi_chip_fail_sync_o,
   output logic multi_chip_fail_sync_oe,
   output logic start_power_down,
   output logic start_power_up,
   output logic reload_fuses,
   output logic soft_wd_reset,
   output logic [6:0] slave_addr,
   output logic bus_byte_latch,
   output logic bus_byte_nack
);
   logic [3:0] ctrl;
   logic [safe_state_pkg::NFLAG-1:0] flags;
   logic safe_asserted;
   logic wdi_prev;
   logic [3:0] bit_count;
   safe_state_pkg::seq_t state;
   safe_state_pkg::seq_t next_state;
   logic lead_done;
   logic deb_done;
   logic rel_done;

   // Watchdog functions suppressed in test configuration
   wire wd_allowed = !config_test_pin;
   wire wdi_event = wd_allowed && watchdog_input && !wdi_prev;
   wire wdi_hard = wdi_event && fuse_reset_kind;
   wire wdi_soft = wdi_event && !fuse_reset_kind;
   wire cnt_event = wd_allowed && counter_wd_reset;
   wire soft_event = regulator_fault || current_limit_fault;
   wire hard_event = fault_timer_expired || regulator_fault_limit || watchdog_event_limit
                     || power_up_failure || thermal_shutdown;
   wire active_mode = fuse_active_safe_mode;
   wire is_off = (state == safe_state_pkg::ST_OFF);

   // Sticky flag sets per source
   wire set_soft = ctrl[safe_state_pkg::S_SOFT] && soft_event;
   wire set_wdi = ctrl[safe_state_pkg::S_WDI] && wdi_event;
   wire set_cnt = ctrl[safe_state_pkg::S_CNT] && cnt_event;
   wire set_hard = ctrl[safe_state_pkg::S_HARD] && hard_event;

   // Safe-state entry in active mode
   wire enter_safe = active_mode && fuse_loaded
                     && (analog_self_test || set_wdi || set_soft || wdi_hard
                         || (is_off && !host_reset_out));
   wire exit_ok = host_reset_out && !analog_self_test && !soft_event
                  && !(ctrl[safe_state_pkg::S_WDI] && flags[safe_state_pkg::F_WDI])
                  && !(ctrl[safe_state_pkg::S_SOFT] && flags[safe_state_pkg::F_SOFT]);

   wire [safe_state_pkg::NFLAG-1:0] set_vec = {set_hard, set_cnt, set_wdi, set_soft, enter_safe};
   wire flags_wr = wr && (addr == safe_state_pkg::REG_FLAGS);
   // Hold flag in active mode only clears once exit conditions hold
   wire [safe_state_pkg::NFLAG-1:0] clr_mask = {{(safe_state_pkg::NFLAG-1){1'b1}},
                                                exit_ok || !active_mode};
   wire [safe_state_pkg::NFLAG-1:0] clr_vec = flags_wr ? (wdata[safe_state_pkg::NFLAG-1:0] & clr_mask)
                                              : '0;
   wire [safe_state_pkg::NFLAG-1:0] next_flags;

   genvar gi;
   generate
      for (gi = 0; gi < safe_state_pkg::NFLAG; gi++)
      begin : g_flag
         // Set wins over a same-cycle clear
         assign next_flags[gi] = set_vec[gi] | (flags[gi] & ~clr_vec[gi]);
      end
   endgenerate

   // Output decision
   wire any_flag = |next_flags;
   wire hold_active = active_mode && next_flags[safe_state_pkg::F_HOLD];
   wire next_safe = input_undervoltage_detect ? 1'b0
                    : active_mode ? (fuse_loaded && (hold_active || enter_safe
                                     || (|next_flags[safe_state_pkg::NFLAG-1:1])))
                    : any_flag;

   // Sequencer: external fail detection and internal causes
   wire sync_en = fuse_sync_enable;
   wire sync_low = sync_en && !multi_chip_fail_sync_in;
   wire internal_off = hard_event || wdi_hard;
   wire ext_fail = deb_done && (state == safe_state_pkg::ST_ON);

   always_comb
   begin
      next_state = state;
      case (state)
         safe_state_pkg::ST_OFF:
            if (power_on_input)
               next_state = safe_state_pkg::ST_WAIT_UP;
         safe_state_pkg::ST_WAIT_UP:
            if (!sync_low)
               next_state = safe_state_pkg::ST_ON;
         safe_state_pkg::ST_ON:
            if (internal_off || ext_fail)
               next_state = (sync_en && !ext_fail) ? safe_state_pkg::ST_LEAD
                            : safe_state_pkg::ST_DOWN;
         safe_state_pkg::ST_LEAD:
            if (lead_done)
               next_state = safe_state_pkg::ST_DOWN;
         safe_state_pkg::ST_DOWN:
            if (outputs_off)
               next_state = safe_state_pkg::ST_RELEASE;
         safe_state_pkg::ST_RELEASE:
            if (rel_done)
               next_state = safe_state_pkg::ST_OFF;
         default:
            next_state = safe_state_pkg::ST_OFF;
      endcase
   end

   wire next_sync_drive = sync_en && (state != safe_state_pkg::ST_WAIT_UP)
                          && (state != safe_state_pkg::ST_ON || ext_fail)
                          && (next_state != safe_state_pkg::ST_WAIT_UP);
   wire next_pd = (state != safe_state_pkg::ST_DOWN) && (next_state == safe_state_pkg::ST_DOWN);
   wire next_pu = (state == safe_state_pkg::ST_WAIT_UP) && (next_state == safe_state_pkg::ST_ON);
   wire next_reload = rel_done && (state == safe_state_pkg::ST_RELEASE);

   // Bus address and byte framing
   wire [6:0] next_addr = config_test_pin ? safe_state_pkg::TEST_ADDR
                          : safe_state_pkg::BASE_ADDR + {4'h0, fuse_addr_sel};
   wire byte_full = (bit_count == safe_state_pkg::BYTE_BITS);
   wire word_ok = bus_word_end && byte_full;
   wire word_short = bus_word_end && !byte_full;

   wire [7:0] status_vec = {2'h0, sync_low, safe_asserted, 1'b0, state};
   wire [7:0] next_rdata = !rd ? 8'h00
                           : (addr == safe_state_pkg::REG_CTRL) ? {4'h0, ctrl}
                           : (addr == safe_state_pkg::REG_FLAGS) ? {3'h0, flags}
                           : (addr == safe_state_pkg::REG_STATUS) ? status_vec
                           : 8'h00;

   safe_state_cnt #(.LIMIT(safe_state_pkg::SYNC_LEAD_CYC)) u_lead (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .run(state == safe_state_pkg::ST_LEAD),
      .done(lead_done)
   );

   safe_state_cnt #(.LIMIT(safe_state_pkg::SYNC_DEBOUNCE_CYC)) u_deb (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .run(sync_low && state == safe_state_pkg::ST_ON && !multi_chip_fail_sync_oe),
      .done(deb_done)
   );

   safe_state_cnt #(.LIMIT(safe_state_pkg::SYNC_RELEASE_CYC)) u_rel (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .run(state == safe_state_pkg::ST_RELEASE),
      .done(rel_done)
   );

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flags <= '0;
         ctrl <= safe_state_pkg::CTRL_RESET;
         wdi_prev <= 1'b0;
         state <= safe_state_pkg::ST_OFF;
      end
      else
      begin
         flags <= next_flags;
         if (wr && addr == safe_state_pkg::REG_CTRL)
            ctrl <= wdata[3:0];
         wdi_prev <= watchdog_input;
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         safe_asserted <= 1'b0;
         safe_state_out_o <= 1'b0;
         safe_state_out_oe <= 1'b0;
         multi_chip_fail_sync_o <= 1'b0;
         multi_chip_fail_sync_oe <= 1'b0;
      end
      else
      begin
         safe_asserted <= next_safe;
         safe_state_out_o <= 1'b0;
         safe_state_out_oe <= next_safe;
         multi_chip_fail_sync_o <= 1'b0;
         multi_chip_fail_sync_oe <= next_sync_drive;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata <= 8'h00;
         start_power_down <= 1'b0;
         start_power_up <= 1'b0;
         reload_fuses <= 1'b0;
         soft_wd_reset <= 1'b0;
         slave_addr <= safe_state_pkg::BASE_ADDR;
         bit_count <= 4'h0;
         bus_byte_latch <= 1'b0;
         bus_byte_nack <= 1'b0;
      end
      else
      begin
         rdata <= next_rdata;
         start_power_down <= next_pd;
         start_power_up <= next_pu;
         reload_fuses <= next_reload;
         soft_wd_reset <= wdi_soft;
         slave_addr <= next_addr;
         if (bus_word_end)
            bit_count <= 4'h0;
         else if (bus_bit_strobe && !byte_full)
            bit_count <= bit_count + 4'h1;
         bus_byte_latch <= word_ok;
         bus_byte_nack <= word_short;
      end
   end
endmodule : safe_state_top
`default_nettype wire

// ===== sim/safe_state_assertions.sv
// Port-level checker for the safe-state and failure-sync block
`timescale 1ns/1ps
`default_nettype none
module safe_state_assertions (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic fuse_loaded,
   input wire logic fuse_active_safe_mode,
   input wire logic fuse_sync_enable,
   input wire logic [2:0] fuse_addr_sel,
   input wire logic config_test_pin,
   input wire logic analog_self_test,
   input wire logic input_undervoltage_detect,
   input wire logic multi_chip_fail_sync_in,
   input wire logic bus_word_end,
   input wire logic safe_state_out_o,
   input wire logic safe_state_out_oe,
   input wire logic multi_chip_fail_sync_oe,
   input wire logic start_power_down,
   input wire logic start_power_up,
   input wire logic [6:0] slave_addr,
   input wire logic bus_byte_latch,
   input wire logic bus_byte_nack
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   a_pin_open_drain: assert property (!safe_state_out_o)
      else $error("safe output driven high");
   a_uv_release: assert property (input_undervoltage_detect |=> !safe_state_out_oe)
      else $error("safe output held under undervoltage");
   a_sync_ignored: assert property (!fuse_sync_enable |-> !multi_chip_fail_sync_oe)
      else $error("sync pin driven while disabled");
   a_addr_map: assert property (!config_test_pin |=> slave_addr == 7'h08 + {4'h0, $past(fuse_addr_sel)})
      else $error("slave address wrong");
   a_byte_frame: assert property (bus_word_end |=> bus_byte_latch != bus_byte_nack)
      else $error("word end without single verdict");
   a_down_synced: assert property (fuse_sync_enable && start_power_down |-> multi_chip_fail_sync_oe)
      else $error("power down without sync low");
   a_up_released: assert property (start_power_up |-> $past(multi_chip_fail_sync_in) && !multi_chip_fail_sync_oe)
      else $error("power up while sync held");
   a_self_test_safe: assert property (fuse_active_safe_mode && fuse_loaded && analog_self_test && !input_undervoltage_detect |=> safe_state_out_oe)
      else $error("self test fault left output released");
   c_power_up: cover property (start_power_up);
   c_power_down: cover property (start_power_down);
   c_byte_nack: cover property (bus_byte_nack);
endmodule : safe_state_assertions
bind safe_state_top safe_state_assertions safe_state_assertions_i (.*);
`default_nettype wire

// ===== sim/peer_sync_model.sv
// Companion power chip on the shared failure-sync wire
`timescale 1ns/1ps
`default_nettype none
module peer_sync_model (
   input wire logic clk_sys,
   input wire logic hold,
   input wire logic dut_oe,
   output logic wire_level
);
   logic peer_oe;
   // Peer keeps the wire low until it is ready
   always_ff @(posedge clk_sys)
      peer_oe <= hold;
   // Pull-up wins once both ends release
   assign wire_level = !(dut_oe || peer_oe);
endmodule : peer_sync_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the safe-state and failure-sync block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic arst_n, fuse_loaded, fuse_active_safe_mode, fuse_sync_enable, fuse_reset_kind;
   logic config_test_pin, host_reset_out, analog_self_test, watchdog_input, counter_wd_reset;
   logic input_undervoltage_detect, power_on_input, outputs_off, bus_bit_strobe, bus_word_end;
   logic wr, rd, peer_hold, multi_chip_fail_sync_in, safe_state_out_o, safe_state_out_oe;
   logic multi_chip_fail_sync_o, multi_chip_fail_sync_oe, start_power_down, start_power_up;
   logic reload_fuses, soft_wd_reset, bus_byte_latch, bus_byte_nack;
   logic [2:0] fuse_addr_sel;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic [4:0] hf;
   logic [1:0] sf;
   logic [6:0] slave_addr;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;
   safe_state_top safe_state_top_i (.fault_timer_expired(hf[0]), .regulator_fault_limit(hf[1]),
      .watchdog_event_limit(hf[2]), .power_up_failure(hf[3]), .thermal_shutdown(hf[4]),
      .regulator_fault(sf[0]), .current_limit_fault(sf[1]), .*);
   peer_sync_model peer_sync_model_i (.clk_sys(clk_sys), .hold(peer_hold),
      .dut_oe(multi_chip_fail_sync_oe), .wire_level(multi_chip_fail_sync_in));
   always #12.5 clk_sys = ~clk_sys;
   task automatic end_of_test();
      $display("errors=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      chk(rdata & m, exp);
   endtask : rd_chk
   task automatic wait_evt(input int w);
      n = 0;
      while (n < 3000 && !(w == 0 ? start_power_up : w == 1 ? start_power_down : reload_fuses))
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask : wait_evt
   task automatic do_reset(input logic act, input logic sync);
      @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      fuse_active_safe_mode <= act;
      fuse_sync_enable <= sync;
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
   endtask : do_reset
   task automatic t_regs();
      rd_chk(4'h0, 8'hFF, 8'h00);
      rd_chk(4'h1, 8'hFF, 8'h00);
      wr_reg(4'hF, 8'hFF);
      rd_chk(4'hF, 8'hFF, 8'h00);
      rd_chk(4'h0, 8'hFF, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk_sys);
         fuse_addr_sel <= 3'(i);
         tick(2);
         chk({1'b0, slave_addr}, 8'h08 + 8'(i));
      end
      @(posedge clk_sys);
      config_test_pin <= 1'b1;
      tick(2);
      chk({1'b0, slave_addr}, 8'h08);
      for (int j = 0; j < 2; j++)
      begin
         repeat (8 - j)
         begin
            @(posedge clk_sys);
            bus_bit_strobe <= 1'b1;
            @(posedge clk_sys);
            bus_bit_strobe <= 1'b0;
         end
         @(posedge clk_sys);
         bus_word_end <= 1'b1;
         @(posedge clk_sys);
         bus_word_end <= 1'b0;
         #1;
         chk({6'h00, bus_byte_latch, bus_byte_nack}, j ? 8'h01 : 8'h02);
      end
      config_test_pin <= 1'b0;
   endtask : t_regs
   task automatic t_flags();
      logic [7:0] sel;
      logic [7:0] flag;
      for (int k = 0; k < 8; k++)
      begin
         sel = k < 5 ? 8'h08 : k < 7 ? 8'h01 : 8'h04;
         flag = sel << 1;
         for (int s = 0; s < 2; s++)
         begin
            wr_reg(4'h0, s ? sel : 8'h00);
            @(posedge clk_sys);
            {counter_wd_reset, sf, hf} <= 8'h01 << k;
            @(posedge clk_sys);
            {counter_wd_reset, sf, hf} <= 8'h00;
            tick(3);
            chk_bit(safe_state_out_oe, 1'(s));
            rd_chk(4'h1, 8'hFF, s ? flag : 8'h00);
         end
         wr_reg(4'h1, ~flag);
         rd_chk(4'h1, 8'hFF, flag);
         @(posedge clk_sys);
         input_undervoltage_detect <= 1'b1;
         tick(2);
         chk_bit(safe_state_out_oe, 1'b0);
         @(posedge clk_sys);
         input_undervoltage_detect <= 1'b0;
         wr_reg(4'h1, flag);
         tick(2);
         chk_bit(safe_state_out_oe, 1'b0);
      end
   endtask : t_flags
   task automatic t_sync();
      chk_bit(multi_chip_fail_sync_oe, 1'b1);
      @(posedge clk_sys);
      host_reset_out <= 1'b1;
      peer_hold <= 1'b1;
      power_on_input <= 1'b1;
      tick(20);
      rd_chk(4'h2, 8'h07, 8'h01);
      @(posedge clk_sys);
      peer_hold <= 1'b0;
      wait_evt(0);
      chk_bit(n < 10, 1'b1);
      power_on_input <= 1'b0;
      wr_reg(4'h0, 8'h02);
      for (int t = 1; t >= 0; t--)
      begin
         @(posedge clk_sys);
         config_test_pin <= 1'(t);
         watchdog_input <= 1'b1;
         @(posedge clk_sys);
         watchdog_input <= 1'b0;
         tick(3);
         rd_chk(4'h1, 8'hFF, t ? 8'h00 : 8'h04);
      end
      wr_reg(4'h1, 8'h04);
      wr_reg(4'h0, 8'h00);
      @(posedge clk_sys);
      hf <= 5'h01;
      wait_evt(1);
      chk_bit(n >= 800 && n <= 806, 1'b1);
      hf <= 5'h00;
      outputs_off <= 1'b1;
      wait_evt(2);
      chk_bit(n >= 1200 && n <= 1206, 1'b1);
      outputs_off <= 1'b0;
      power_on_input <= 1'b1;
      wait_evt(0);
      power_on_input <= 1'b0;
      peer_hold <= 1'b1;
      wait_evt(1);
      chk_bit(n >= 800 && n <= 806, 1'b1);
      chk_bit(multi_chip_fail_sync_oe, 1'b1);
      peer_hold <= 1'b0;
   endtask : t_sync
   task automatic t_active();
      @(posedge clk_sys);
      host_reset_out <= 1'b0;
      fuse_loaded <= 1'b0;
      do_reset(1'b1, 1'b0);
      tick(3);
      chk_bit(safe_state_out_oe, 1'b0);
      @(posedge clk_sys);
      fuse_loaded <= 1'b1;
      tick(3);
      chk_bit(safe_state_out_oe, 1'b1);
      rd_chk(4'h1, 8'h01, 8'h01);
      chk_bit(multi_chip_fail_sync_oe, 1'b0);
      @(posedge clk_sys);
      host_reset_out <= 1'b1;
      wr_reg(4'h1, 8'h1F);
      tick(2);
      chk_bit(safe_state_out_oe, 1'b0);
      @(posedge clk_sys);
      analog_self_test <= 1'b1;
      tick(3);
      chk_bit(safe_state_out_oe, 1'b1);
      wr_reg(4'h1, 8'h01);
      rd_chk(4'h1, 8'h01, 8'h01);
      @(posedge clk_sys);
      analog_self_test <= 1'b0;
      sf <= 2'h1;
      wr_reg(4'h1, 8'h01);
      rd_chk(4'h1, 8'h01, 8'h01);
      @(posedge clk_sys);
      sf <= 2'h0;
      wr_reg(4'h1, 8'h01);
      tick(2);
      chk_bit(safe_state_out_oe, 1'b0);
   endtask : t_active
   initial
   begin
      {arst_n, fuse_active_safe_mode, fuse_reset_kind, config_test_pin, host_reset_out} = '0;
      {analog_self_test, watchdog_input, counter_wd_reset, input_undervoltage_detect} = '0;
      {power_on_input, outputs_off, bus_bit_strobe, bus_word_end, wr, rd, peer_hold} = '0;
      {fuse_addr_sel, addr, wdata, hf, sf} = '0;
      fuse_loaded = 1'b1;
      fuse_sync_enable = 1'b1;
      do_reset(1'b0, 1'b1);
      t_regs();
      t_flags();
      t_sync();
      t_active();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
